// ==== rtl/cur_gauge_pkg.sv ====
// Summary of operation
// RULE_01 - Modulator bitstream is digitally filtered into a multi-bit current value.
// RULE_02 - Pulse output is high while the free-running ramp is below the value.
// RULE_03 - Current is averaged over consecutive fixed slots of nominally 50 ms.
// RULE_04 - Zero averaged current gives a 50% duty cycle.
// RULE_05 - Positive current gives duty above half, negative below half.
// RULE_06 - Full scale gives 95.5% duty, negative full scale 4.5%.
// RULE_07 - Current equals 2.2 times duty minus 0.5, times full scale.
// RULE_08 - Signed range to full scale; full scale fixed per build, 1.0A or 2.0A.
// RULE_09 - Waveform repeats near 20 Hz, always within 12.5 Hz to 25 Hz.
// RULE_10 - Normal operation while shutdown input high, low power while low.
// RULE_11 - Duty is quantized into 1024 steps by a 10-bit ramp.
// RULE_12 - Every pulse carries an extra half step: duty is (N + 1/2) / 1024.
// RULE_13 - Each interval shows the duty coding the previous interval's average.
// RULE_14 - Shutdown holds the output low, clears averaging, restarts fresh afterwards.
`default_nettype none

package cur_gauge_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SAMPLE_TIME_MS = 50;
  localparam int unsigned RAMP_BITS = 10;
  localparam int unsigned HALF_STEPS = 2 ** (RAMP_BITS + 1);
  // Cycles per half ramp step; rounding down keeps the interval just under 50 ms
  localparam int unsigned HALF_STEP_CYC = (CLK_HZ / 1000) * SAMPLE_TIME_MS / HALF_STEPS;

  // ****************************************
  // Code mapping
  // ****************************************
  localparam int unsigned ACC_BITS = RAMP_BITS + 2;
  localparam logic [RAMP_BITS-1:0] MID_CODE = 10'h200;
  localparam logic signed [ACC_BITS:0] HALF_ONES = 13'sh0400;
  // 1 / 2.2 code per count of density offset, scaled by 2^12
  localparam logic signed [11:0] SCALE_K = 12'sh746;
  localparam int unsigned SCALE_SHIFT = 12;
  localparam logic [RAMP_BITS-1:0] POS_FS_CODE = 10'h3d1;
  localparam logic [RAMP_BITS-1:0] NEG_FS_CODE = 10'h02e;

  // ****************************************
  // Build options
  // ****************************************
  localparam int unsigned FS_1A_MA = 1000;
  localparam int unsigned FS_2A_MA = 2000;

endpackage

`default_nettype wire

// ==== rtl/half_step_ramp.sv ====
`timescale 1ns/1ps
`default_nettype none

module half_step_ramp
  import cur_gauge_pkg::*;
#(
  parameter int unsigned CODE_BITS = RAMP_BITS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Control
  input wire logic clear_i,
  input wire logic step_en_i,
  input wire logic [CODE_BITS-1:0] level_i,
  // Results
  output logic wrap_o,
  output logic pwm_o
);

  logic [CODE_BITS:0] half_q;
  logic [CODE_BITS:0] half_d;
  logic pwm_q;
  logic pwm_d;

  // A ramp needs at least one code bit to compare against
  if (CODE_BITS < 1) begin : g_bad_bits
    $error("Ramp needs at least one code bit");
  end

  // ****************************************
  // Ramp and compare
  // ****************************************
  // Ramp counts half steps so the extra half step needs no second counter
  always_comb begin
    half_d = half_q;
    if (clear_i) begin
      half_d = '0;
    end else if (step_en_i) begin
      half_d = half_q + 1'b1; // RULE_11
    end
    // Level N stays high for 2N+1 half steps
    pwm_d = !clear_i && (half_q < {level_i, 1'b1}); // RULE_02 RULE_12
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      half_q <= '0;
      pwm_q <= 1'b0;
    end else begin
      half_q <= half_d;
      pwm_q <= pwm_d;
    end
  end

  assign wrap_o = step_en_i && (half_q == '1);
  assign pwm_o = pwm_q;

  // ****************************************
  // Checks
  // ****************************************
  AST_HALF_STEP_HIGH: assert property ( // RULE_12
    @(posedge clk_i) disable iff (!rstn_i)
    (!clear_i && half_q == '0) |=> pwm_o
  ) else $error("Pulse missing its leading half step");

  AST_RAMP_CUTOFF: assert property ( // RULE_02
    @(posedge clk_i) disable iff (!rstn_i)
    (!clear_i && half_q == {level_i, 1'b1}) |=> !pwm_o
  ) else $error("Pulse still high at ramp crossing");

  AST_RAMP_WRAP: assert property ( // RULE_11
    @(posedge clk_i) disable iff (!rstn_i)
    (wrap_o && !clear_i) |=> (half_q == '0)
  ) else $error("Ramp did not wrap after its last step");

endmodule

`default_nettype wire

// ==== rtl/current_average_pwm_encoder.sv ====
`timescale 1ns/1ps
`default_nettype none

module current_average_pwm_encoder
  import cur_gauge_pkg::*;
#(
  parameter int unsigned FULL_SCALE_MA = FS_1A_MA,
  parameter int unsigned STEP_CYC = HALF_STEP_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Shutdown control, low means low power
  input wire logic low_power_request_n_i,
  // Modulator pulse-density bitstream
  input wire logic mod_bit_i,
  // Encoded output
  output logic pwm_o,
  // Observation of the held code and interval boundary
  output logic [RAMP_BITS-1:0] avg_code_o,
  output logic interval_start_o
);

  // ****************************************
  // Build checks
  // ****************************************
  localparam int unsigned DIV_BITS = (STEP_CYC > 1) ? $clog2(STEP_CYC) : 1;
  localparam logic [DIV_BITS-1:0] DIV_LAST = DIV_BITS'(STEP_CYC - 1);

  // Full scale is a build option only; the digital mapping is normalized to it
  generate
    if (FULL_SCALE_MA != FS_1A_MA && FULL_SCALE_MA != FS_2A_MA) begin : g_bad_fs
      $error("Full scale must be 1000 or 2000 mA"); // RULE_08
    end
    if (STEP_CYC < 2) begin : g_bad_step
      $error("Half step must span at least two cycles");
    end
    // A longer half step stretches the interval past its nominal 50 ms
    if (STEP_CYC > HALF_STEP_CYC) begin : g_slow_step
      $error("Half step longer than the nominal interval allows"); // RULE_03
    end
    if ((2 ** ACC_BITS) <= HALF_STEPS) begin : g_narrow_acc
      $error("Accumulator too narrow for one interval of samples");
    end
  endgenerate

  // ****************************************
  // Declarations
  // ****************************************
  logic run;
  logic tick;
  logic boundary;
  logic [DIV_BITS-1:0] div_q;
  logic [DIV_BITS-1:0] div_d;
  logic [ACC_BITS-1:0] acc_q;
  logic [ACC_BITS-1:0] acc_d;
  logic [ACC_BITS-1:0] ones;
  logic signed [ACC_BITS:0] diff;
  logic signed [24:0] prod;
  logic signed [24:0] scaled;
  logic [24:0] code_sum;
  logic [RAMP_BITS-1:0] code_new;
  logic [RAMP_BITS-1:0] code_q;
  logic [RAMP_BITS-1:0] code_d;
  logic start_q;
  logic start_d;

  // Shutdown pin gates everything
  assign run = low_power_request_n_i; // RULE_10

  // ****************************************
  // Half step divider
  // ****************************************
  // One tick per half ramp step; the ramp then repeats about every 50 ms
  assign tick = run && (div_q == DIV_LAST); // RULE_09

  always_comb begin
    div_d = div_q + 1'b1;
    if (!run || tick) begin
      div_d = '0; // RULE_14
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // ****************************************
  // Ramp and pulse generator
  // ****************************************
  half_step_ramp #(
    .CODE_BITS(RAMP_BITS)
  ) u_ramp (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .clear_i(!run),
    .step_en_i(tick),
    .level_i(code_q),
    .wrap_o(boundary),
    .pwm_o(pwm_o)
  );

  // ****************************************
  // Averaging filter
  // ****************************************
  // One bit sampled per half step; the interval is the ramp period, so
  // sampling and display stay locked without a second timer
  assign ones = acc_q + {{(ACC_BITS-1){1'b0}}, mod_bit_i}; // RULE_01

  always_comb begin
    acc_d = acc_q;
    if (!run) begin
      acc_d = '0; // RULE_14
    end else if (boundary) begin
      acc_d = '0; // RULE_03
    end else if (tick) begin
      acc_d = ones; // RULE_01
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end

  // ****************************************
  // Density to duty code
  // ****************************************
  // Half density maps to mid code; the slope of 1/2.2 places the rails
  // near 4.5% and 95.5%, and the floor of the shift is harmless there
  always_comb begin
    diff = $signed({1'b0, ones}) - HALF_ONES; // RULE_04 RULE_05
    prod = 25'(diff) * 25'(SCALE_K); // RULE_07
    scaled = prod >>> SCALE_SHIFT; // RULE_06
    code_sum = 25'(scaled) + 25'(MID_CODE);
    code_new = code_sum[RAMP_BITS-1:0];
  end

  // ****************************************
  // Held code
  // ****************************************
  // After shutdown the first interval shows zero current, as nothing was averaged
  always_comb begin
    code_d = code_q;
    start_d = 1'b0;
    if (!run) begin
      code_d = MID_CODE; // RULE_14
    end else if (boundary) begin
      code_d = code_new; // RULE_13
      start_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      code_q <= MID_CODE;
      start_q <= 1'b0;
    end else begin
      code_q <= code_d;
      start_q <= start_d;
    end
  end

  assign avg_code_o = code_q;
  assign interval_start_o = start_q;

  // ****************************************
  // Interval watch
  // ****************************************
  // Cycles since the last boundary, read only by the checks; an interval is far
  // longer than any repetition count can reasonably span
  localparam int unsigned INTERVAL_CYC = HALF_STEPS * STEP_CYC;
  localparam int unsigned GAP_BITS = $clog2(INTERVAL_CYC);
  localparam logic [GAP_BITS-1:0] GAP_LAST = GAP_BITS'(INTERVAL_CYC - 1);

  logic [GAP_BITS-1:0] gap_q;
  logic [GAP_BITS-1:0] gap_d;

  // Restarts with the slot, so a shutdown release begins a full interval
  always_comb begin
    gap_d = gap_q + 1'b1;
    if (!run || boundary) begin
      gap_d = '0; // RULE_14
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gap_q <= '0;
    end else begin
      gap_q <= gap_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_SHDN_PWM_LOW: assert property ( // RULE_14
    @(posedge clk_i) disable iff (!rstn_i)
    !low_power_request_n_i |=> !pwm_o
  ) else $error("Pulse output not low in shutdown");

  AST_SHDN_CLEARS: assert property ( // RULE_10
    @(posedge clk_i) disable iff (!rstn_i)
    !low_power_request_n_i |=> (acc_q == '0 && div_q == '0 && code_q == MID_CODE)
  ) else $error("Shutdown did not clear averaging state");

  AST_TICK_SPACING: assert property ( // RULE_09
    @(posedge clk_i) disable iff (!rstn_i)
    (tick && low_power_request_n_i) |=> (div_q == '0 && !tick)
  ) else $error("Half step divider spacing wrong");

  AST_ACCUMULATE: assert property ( // RULE_01
    @(posedge clk_i) disable iff (!rstn_i)
    (tick && !boundary) |=> (acc_q == $past(acc_q) + ACC_BITS'($past(mod_bit_i)))
  ) else $error("Bitstream sample not accumulated");

  AST_SLOT_RESTART: assert property ( // RULE_03
    @(posedge clk_i) disable iff (!rstn_i)
    (boundary && low_power_request_n_i) |=> (acc_q == '0) ##1 (acc_q == '0)
  ) else $error("Averaging slot did not restart");

  AST_ZERO_MID: assert property ( // RULE_04
    @(posedge clk_i) disable iff (!rstn_i)
    (boundary && ones == 12'h400) |=> (code_q == MID_CODE)
  ) else $error("Zero current not encoded as half duty");

  AST_SIGN_SIDE: assert property ( // RULE_05
    @(posedge clk_i) disable iff (!rstn_i)
    boundary |=> (($past(ones) < 12'h400) == (code_q < MID_CODE))
  ) else $error("Duty on wrong side of half for current sign");

  AST_FULL_SCALE_POS: assert property ( // RULE_06
    @(posedge clk_i) disable iff (!rstn_i)
    (boundary && ones == 12'h800) |=> (code_q == POS_FS_CODE)
  ) else $error("Positive full scale code wrong");

  AST_FULL_SCALE_NEG: assert property ( // RULE_08
    @(posedge clk_i) disable iff (!rstn_i)
    (boundary && ones == 12'h000) |=> (code_q == NEG_FS_CODE)
  ) else $error("Negative full scale code wrong");

  AST_LINEAR_STEP: assert property ( // RULE_07
    @(posedge clk_i) disable iff (!rstn_i)
    (boundary && ones == 12'h600) |=> (code_q == 10'h2e8)
  ) else $error("Mid range code off the linear law");

  AST_CODE_HELD: assert property ( // RULE_13
    @(posedge clk_i) disable iff (!rstn_i)
    (low_power_request_n_i && !boundary) |=> $stable(code_q)
  ) else $error("Displayed code changed inside an interval");

  AST_START_PULSE: assert property ( // RULE_13
    @(posedge clk_i) disable iff (!rstn_i)
    (boundary && low_power_request_n_i) |=> interval_start_o ##1 !interval_start_o
  ) else $error("Interval start pulse wrong");

  AST_INTERVAL_LENGTH: assert property ( // RULE_03
    @(posedge clk_i) disable iff (!rstn_i)
    boundary |-> (gap_q == GAP_LAST)
  ) else $error("Averaging interval has the wrong length");

  AST_DIV_RANGE: assert property ( // RULE_09
    @(posedge clk_i) disable iff (!rstn_i)
    div_q <= DIV_LAST
  ) else $error("Half step divider out of range");

  AST_DIV_COUNT: assert property ( // RULE_09
    @(posedge clk_i) disable iff (!rstn_i)
    (low_power_request_n_i && !tick) |=> (div_q == DIV_BITS'($past(div_q) + 1'b1))
  ) else $error("Half step divider skipped a count");

  AST_ACC_BOUND: assert property ( // RULE_03
    @(posedge clk_i) disable iff (!rstn_i)
    acc_q < ACC_BITS'(HALF_STEPS)
  ) else $error("Accumulator holds more than one interval");

  AST_ACC_IDLE: assert property ( // RULE_01
    @(posedge clk_i) disable iff (!rstn_i)
    (low_power_request_n_i && !tick) |=> $stable(acc_q)
  ) else $error("Accumulator changed between samples");

  AST_CODE_RANGE: assert property ( // RULE_08
    @(posedge clk_i) disable iff (!rstn_i)
    (code_q >= NEG_FS_CODE) && (code_q <= POS_FS_CODE)
  ) else $error("Held code outside the full scale span");

  AST_START_AFTER_BOUNDARY: assert property ( // RULE_13
    @(posedge clk_i) disable iff (!rstn_i)
    interval_start_o |-> $past(boundary)
  ) else $error("Interval start without a boundary");

  AST_RELEASE_FRESH: assert property ( // RULE_14
    @(posedge clk_i) disable iff (!rstn_i)
    $rose(low_power_request_n_i) |-> (acc_q == '0 && div_q == '0 && code_q == MID_CODE)
  ) else $error("Shutdown release did not start fresh");

  AST_WRAP_LOW: assert property ( // RULE_02
    @(posedge clk_i) disable iff (!rstn_i)
    boundary |=> !pwm_o
  ) else $error("Pulse high across the ramp wrap");

  AST_WRAP_RISE: assert property ( // RULE_02
    @(posedge clk_i) disable iff (!rstn_i)
    (boundary && low_power_request_n_i) ##1 low_power_request_n_i |=> pwm_o
  ) else $error("Pulse did not start after the ramp wrap");

endmodule

`default_nettype wire

// ==== bench/pwm_duty_meter.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Capture timer of the reading controller
// ****************************************
module pwm_duty_meter (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Observed pulse output
  input wire logic pwm_i,
  // Last complete period, in clock cycles
  output logic [31:0] high_cyc_o,
  output logic [31:0] period_cyc_o
);
  logic pwm_q;
  logic [31:0] high_q;
  logic [31:0] per_q;

  // Rise to rise timing; the reader turns high over period into current
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwm_q <= 1'b0;
      high_q <= '0;
      per_q <= '0;
      high_cyc_o <= '0;
      period_cyc_o <= '0;
    end else begin
      pwm_q <= pwm_i;
      if (pwm_i && !pwm_q) begin
        high_cyc_o <= high_q;
        period_cyc_o <= per_q;
        high_q <= 32'h1;
        per_q <= 32'h1;
      end else begin
        per_q <= per_q + 32'h1;
        if (pwm_i) begin
          high_q <= high_q + 32'h1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ==== bench/test_current_average_pwm_encoder.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_current_average_pwm_encoder
  import cur_gauge_pkg::*;
;
  // Short half step keeps an interval at 4096 cycles
  localparam int S = 2;
  localparam int LIMIT = 70000;
  logic clk_i, rstn_i, lp_n, mod_bit, pwm, istart;
  logic [RAMP_BITS-1:0] avg_code;
  logic [31:0] high_cyc, period_cyc;
  int mode, tcnt, cyc, fails, tests_run;

  current_average_pwm_encoder #(.FULL_SCALE_MA(FS_1A_MA), .STEP_CYC(S)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .low_power_request_n_i(lp_n), .mod_bit_i(mod_bit),
    .pwm_o(pwm), .avg_code_o(avg_code), .interval_start_o(istart));
  pwm_duty_meter meter (.clk_i(clk_i), .rstn_i(rstn_i), .pwm_i(pwm),
    .high_cyc_o(high_cyc), .period_cyc_o(period_cyc));

  // ****************************************
  // Clock, bitstream and hang guard
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Mode 2 toggles every half step so samples alternate exactly
  always @(negedge clk_i) begin
    tcnt <= tcnt + 1;
    if (mode == 2 && (tcnt % S) == 0) mod_bit <= ~mod_bit;
    else if (mode != 2) mod_bit <= (mode == 1);
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails = fails + 1;
      tally_and_finish();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wait_start();
    int n;
    n = 0;
    @(negedge clk_i);
    while (istart !== 1'b1 && n < 2048 * S + 8) begin
      @(negedge clk_i);
      n++;
    end
    chk("interval start", 32'h1, {31'h0, istart});
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic reset_state();
    repeat (20) @(negedge clk_i);
    chk("reset pwm", 32'h0, {31'h0, pwm});
    chk("reset code", {22'h0, MID_CODE}, {22'h0, avg_code});
    rstn_i = 1'b1;
    wait_start();
    repeat (3) @(negedge clk_i);
    chk("zero high", 1025 * S, high_cyc);
  endtask

  // The interval in which the pattern changes mixes samples, so judge the next one
  task automatic level(input int m, input logic [31:0] n);
    mode = m;
    wait_start();
    wait_start();
    chk("code", n, {22'h0, avg_code});
    wait_start();
    repeat (3) @(negedge clk_i);
    chk("high", (2 * n + 1) * S, high_cyc);
    chk("period", 2048 * S, period_cyc);
  endtask

  task automatic shutdown_restart();
    mode = 1;
    repeat (700) @(negedge clk_i);
    lp_n = 1'b0;
    repeat (3) @(negedge clk_i);
    chk("off pwm", 32'h0, {31'h0, pwm});
    chk("off code", {22'h0, MID_CODE}, {22'h0, avg_code});
    repeat (900) @(negedge clk_i);
    chk("still off", 32'h0, {31'h0, pwm});
    lp_n = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("fresh code", {22'h0, MID_CODE}, {22'h0, avg_code});
    wait_start();
    chk("after code", {22'h0, POS_FS_CODE}, {22'h0, avg_code});
    wait_start();
    chk("next code", {22'h0, POS_FS_CODE}, {22'h0, avg_code});
  endtask

  initial begin
    rstn_i = 1'b0;
    lp_n = 1'b1;
    mod_bit = 1'b0;
    mode = 0;
    tcnt = 0;
    cyc = 0;
    fails = 0;
    tests_run = 0;
    reset_state();
    level(0, {22'h0, NEG_FS_CODE});
    level(1, {22'h0, POS_FS_CODE});
    level(2, {22'h0, MID_CODE});
    chk("mid code", {22'h0, MID_CODE}, {22'h0, avg_code});
    shutdown_restart();
    tally_and_finish();
  end
endmodule

`default_nettype wire
